// file: verilog/iel_hst.sv
// host end: logs requests, keeps the last mask, polls causes
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
`include "iel_map.svh"
module iel_hst (
   input wire logic clk_i,           // 25 MHz clock
   input wire logic rst_i,           // sync reset, high
   iel_if.hst lk,                    // card link
   input wire logic wb_cyc_i,        // wishbone cycle
   input wire logic wb_stb_i,        // wishbone strobe
   input wire logic wb_we_i,         // wishbone write
   input wire logic [3:0] wb_adr_i,  // wishbone byte address
   input wire logic [31:0] wb_dat_i, // wishbone write data
   input wire logic [3:0] wb_sel_i,  // wishbone byte lanes
   output logic [31:0] wb_dat_o,     // wishbone read data
   output logic wb_ack_o             // wishbone ack
);
   import iel_pkg::*;

   iel_hst_s_t q;   // registered state
   iel_hst_s_t n;   // next state
   logic wb_take;   // new bus access
   logic idle;      // link free

   // next-state logic
   always_comb begin
      n = q;
      n.log = 1'b0;
      wb_take = wb_cyc_i & wb_stb_i & ~q.wb_ack;
      n.wb_ack = wb_take;
      idle = (q.st == IEL_H_IDLE);
      // bus reads
      if (wb_take & ~wb_we_i) begin
         unique case (wb_adr_i)
            `IEL_WB_MASK: n.wb_dat = {16'h0000, q.last_mask};
            `IEL_WB_STAT: n.wb_dat = {25'h0000000, q.lprio, 1'b0, ~idle, q.logged, lk.irq};
            `IEL_WB_CAUSE: n.wb_dat = {16'h0000, q.cause};
            default: n.wb_dat = 32'h00000000;
         endcase
      end
      // bus writes; a command while busy is dropped
      if (wb_take & wb_we_i) begin
         if (wb_adr_i == `IEL_WB_MASK) begin
            if (wb_sel_i[0]) begin
               n.last_mask[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
               n.last_mask[15:8] = wb_dat_i[15:8];
            end
         end else if (wb_adr_i == `IEL_WB_CMD && idle && wb_sel_i[0]) begin
            if (wb_dat_i[`IEL_CMD_EN]) begin
               // enable always rewrites the kept mask
               n.st = IEL_H_BUSY;
               n.stb = 1'b1;
               n.we = 1'b1;
               n.addr = `IEL_REG_MASK;
               n.wdata = q.last_mask;
            end else if (wb_dat_i[`IEL_CMD_POLL]) begin
               n.st = IEL_H_BUSY;
               n.stb = 1'b1;
               n.we = 1'b0;
               n.addr = `IEL_REG_CAUSE;
            end
         end
      end
      // link completion
      if (q.st == IEL_H_BUSY && lk.ack) begin
         n.st = IEL_H_IDLE;
         n.stb = 1'b0;
         if (q.we) begin
            n.logged = 1'b0;
         end else begin
            n.cause = lk.rdata;
         end
      end
      // log a new request once; card disarms itself on the pulse
      // placed after completion: a request seen as the enable lands is logged, not lost or logged twice
      if (lk.irq & ~q.logged) begin
         n.logged = 1'b1;
         n.log = 1'b1;
         n.lprio = lk.prio;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.last_mask <= `IEL_MASK_RST;
      end else begin
         q <= n;
      end
   end

   assign lk.log = q.log;
   assign lk.stb = q.stb;
   assign lk.we = q.we;
   assign lk.addr = q.addr;
   assign lk.wdata = q.wdata;
   assign wb_dat_o = q.wb_dat;
   assign wb_ack_o = q.wb_ack;
endmodule

// file: verilog/iel_map.svh
// constants of the interface interrupt enable logic, with the contract list
// Contract
// - one dedicated request line per interface
// - service request and interface condition causes
// - host writes mask into register 4
// - bit 1 gates service requests; 2 alone
// - host re-enable rewrites last used mask
// - mask never written means zero, all disabled
// - after logging, interface disabled until re-enabled
// - status poll clears the interrupt cause register
// - host re-enables before resuming other work
// - host logs by descending hardware priority
// - priority switch 3 to 6; 7 reserved
`ifndef IEL_MAP_SVH
`define IEL_MAP_SVH
`define IEL_W 16
`define IEL_REG_MASK 4'h4
`define IEL_REG_CAUSE 4'hA
`define IEL_SRQ_BIT 1
`define IEL_MASK_RST 16'h0000
`define IEL_PRIO_MIN 3
`define IEL_PRIO_MAX 6
`define IEL_WB_MASK 4'h0
`define IEL_WB_CMD 4'h4
`define IEL_WB_STAT 4'h8
`define IEL_WB_CAUSE 4'hC
`define IEL_CMD_EN 0
`define IEL_CMD_POLL 2
`define IEL_ST_IRQ 0
`define IEL_ST_LOG 1
`define IEL_ST_BUSY 2
`define IEL_ST_PRIO_LO 4
`endif

// file: verilog/iel_pkg.sv
// types shared by both ends of the interrupt enable link
package iel_pkg;
   typedef enum logic {IEL_H_IDLE = 1'b0, IEL_H_BUSY = 1'b1} iel_hst_t;
   typedef struct packed {
      logic srq_s0;         // first sync stage
      logic srq_s1;         // second sync stage
      logic [15:0] cause;   // sticky cause bits
      logic [15:0] mask;    // enable mask
      logic armed;          // cleared on logging
      logic ack;            // link acknowledge
      logic [15:0] rdata;   // link read data
   } iel_dev_t;
   typedef struct packed {
      iel_hst_t st;         // link fsm
      logic stb;            // link strobe
      logic we;             // link direction
      logic [3:0] addr;     // link register number
      logic [15:0] wdata;   // link write data
      logic [15:0] last_mask; // mask kept for re-enable
      logic [15:0] cause;   // last polled cause
      logic logged;         // event logged, pending service
      logic log;            // one-cycle log pulse
      logic [2:0] lprio;    // priority of logged event
      logic wb_ack;         // bus acknowledge
      logic [31:0] wb_dat;  // bus read data
   } iel_hst_s_t;
endpackage

// file: verilog/iel_if.sv
// link between the interface card and the host
`timescale 1ns/1ns
interface iel_if;
   logic irq;           // request line, card to host
   logic [2:0] prio;    // hardware priority switch
   logic log;           // host logged the event
   logic stb;           // register access strobe
   logic we;            // write when high
   logic [3:0] addr;    // register number
   logic [15:0] wdata;  // write data
   logic ack;           // access done
   logic [15:0] rdata;  // read data
   modport dev (output irq, prio, ack, rdata, input log, stb, we, addr, wdata);
   modport hst (input irq, prio, ack, rdata, output log, stb, we, addr, wdata);
endinterface

// file: verilog/iel_dev.sv
// interface card end: cause register, enable mask and request line
`timescale 1ns/1ns
`include "iel_map.svh"
module iel_dev #(
   parameter int PRIO = `IEL_PRIO_MIN,   // card priority switch
   parameter int W = `IEL_W               // mask width
) (
   input wire logic clk_i,                 // 25 MHz clock
   input wire logic rst_i,                 // sync reset, high
   iel_if.dev lk,                          // host link
   input wire logic srq_i,                 // attached device service request
   input wire logic [`IEL_W-1:0] cond_i,   // interface condition pulses
   output logic [`IEL_W-1:0] cause_o,      // current cause bits
   output logic armed_o                    // card may request
);
   import iel_pkg::*;

   // parameter checks at time zero
   initial begin
      if (PRIO < `IEL_PRIO_MIN || PRIO > `IEL_PRIO_MAX) begin
         $error("card priority out of range");
      end
      if (W != `IEL_W) begin
         $error("mask width unsupported");
      end
   end

   iel_dev_t q;            // registered state
   iel_dev_t n;            // next state
   logic take;             // new link access this cycle
   logic poll;             // status read of cause register
   logic [15:0] set;       // cause bits raised this cycle

   // switch level drives the priority seen by the host
   assign lk.prio = 3'(PRIO);

   // next-state logic
   always_comb begin
      n = q;
      // srq comes from a pin, so two stages before use
      n.srq_s0 = srq_i;
      n.srq_s1 = q.srq_s0;
      // one access per strobe; ack drops after one cycle
      take = lk.stb & ~q.ack;
      n.ack = take;
      poll = take & ~lk.we & (lk.addr == `IEL_REG_CAUSE);
      // internal conditions and external service request
      set = cond_i;
      set[`IEL_SRQ_BIT] = q.srq_s1;
      // poll clears, but a cause raised in the same cycle survives
      if (poll) begin
         n.cause = set;
      end else begin
         n.cause = q.cause | set;
      end
      // register writes from the host
      if (take & lk.we) begin
         if (lk.addr == `IEL_REG_MASK) begin
            n.mask = lk.wdata;
            n.armed = 1'b1;
         end
      end else if (lk.log) begin
         // logged: no further request until re-enabled
         n.armed = 1'b0;
      end
      // read data stands until the next read
      if (take & ~lk.we) begin
         unique case (lk.addr)
            `IEL_REG_MASK: begin
               n.rdata = q.mask;
            end
            `IEL_REG_CAUSE: begin
               n.rdata = q.cause;
            end
            default: begin
               n.rdata = 16'h0000; // unmapped reads zero
            end
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.mask <= `IEL_MASK_RST;
      end else begin
         q <= n;
      end
   end

   // request while armed and any enabled cause remains, bit 1 gates srq
   assign lk.irq = q.armed & |(q.cause & q.mask);
   assign lk.ack = q.ack;
   assign lk.rdata = q.rdata;
   assign cause_o = q.cause;
   assign armed_o = q.armed;
endmodule

// file: tb/iel_checker.sv
// link checker for the interrupt enable logic
`timescale 1ns/1ns
module iel_checker (
   input wire logic clk_i, // clock
   input wire logic rst_i, // sync reset
   input wire logic irq, // card request
   input wire logic [2:0] prio, // priority switch
   input wire logic log, // host logged
   input wire logic stb, // access strobe
   input wire logic we, // write
   input wire logic [3:0] addr, // register number
   input wire logic [15:0] wdata, // write data
   input wire logic ack // access done
);
   logic wr_ff; // a mask reached the card
   // mask write seen since reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_ff <= 1'b0;
      end else if (stb && we && ack) begin
         wr_ff <= 1'b1;
      end
   end
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req; stb && !ack; endsequence
   sequence s_ans; ack ##1 !ack; endsequence
   a_ack_timing: assert property (s_req |=> s_ans) else $error("link ack timing");
   a_req_hold: assert property (s_req |=> $stable(addr) && $stable(we) && $stable(wdata))
      else $error("request moved");
   a_mask_reg: assert property (stb && we |-> addr == 4'h4) else $error("write not reg 4");
   a_poll_reg: assert property (stb && !we |-> addr == 4'hA) else $error("poll reg");
   a_gap_after: assert property (ack |=> !stb) else $error("no gap");
   a_log_pulse: assert property (log |=> !log) else $error("log too long");
   a_log_off: assert property (log && !ack |=> !irq) else $error("still requesting");
   a_irq_logged: assert property ($rose(irq) |-> ##[1:2] log) else $error("not logged");
   a_no_mask: assert property (!wr_ff |-> !irq) else $error("request with no mask");
   a_prio_ok: assert property (prio >= 3'd3 && prio <= 3'd6) else $error("priority range");
endmodule

// file: tb/tb_interface_interrupt_enable_logic.sv
// bench for both ends of the interrupt enable link
`timescale 1ns/1ns
module tb_interface_interrupt_enable_logic;
   logic clk_i = 1'b0; // 25 MHz
   logic rst_i = 1'b1; // held 8 cycles
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // bus request
   logic [3:0] adr = 4'h0; // byte address
   logic [3:0] sel = 4'h0; // byte lanes
   logic [31:0] dat = 32'h0, rd, wb_dat; // bus data
   logic wb_ack, srq = 1'b0, armed; // ack, service request
   logic [15:0] cond = 16'h0, cause; // condition pulses
   int fails = 0, compares = 0, cyc_n = 0;
   always #20 clk_i = ~clk_i; // half period
   iel_if iel_if_i ();
   iel_dev #(.PRIO(5)) iel_dev_i (.clk_i(clk_i), .rst_i(rst_i), .lk(iel_if_i.dev), .srq_i(srq),
      .cond_i(cond), .cause_o(cause), .armed_o(armed));
   // lanes follow each call; every call but the low-lane mask write uses all four lanes
   iel_hst iel_hst_i (.clk_i(clk_i), .rst_i(rst_i), .lk(iel_if_i.hst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
      .wb_dat_o(wb_dat), .wb_ack_o(wb_ack));
   iel_checker iel_checker_i (.clk_i(clk_i), .rst_i(rst_i), .irq(iel_if_i.irq),
      .prio(iel_if_i.prio), .log(iel_if_i.log), .stb(iel_if_i.stb), .we(iel_if_i.we),
      .addr(iel_if_i.addr), .wdata(iel_if_i.wdata), .ack(iel_if_i.ack));
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle; request held until the edge that samples ack high, data taken there
   task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d, input logic [3:0] s = 4'hF);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= s;
      // no local limit: only the hang guard ends a wait
      do begin
         @(posedge clk_i);
      end while (wb_ack !== 1'b1);
      rd = wb_dat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic results;
      if (fails == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // hang guard, far above the run length
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 5000) begin
         fails++;
         results();
      end
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      srq <= 1'b1;
      wb(4'h0, 1'b0, 32'h0);
      chk("mask rst", rd, 32'h0);
      wb(4'h4, 1'b1, 32'h1); // enable with empty mask
      repeat (12) @(posedge clk_i);
      wb(4'h8, 1'b0, 32'h0);
      chk("stat zero mask", rd[2:0], 3'b000);
      chk("srq cause", cause[1], 1'b1);
      wb(4'h0, 1'b1, 32'h2);
      wb(4'h4, 1'b1, 32'h1);
      repeat (12) @(posedge clk_i);
      wb(4'h8, 1'b0, 32'h0);
      chk("stat logged", rd[2:0], 3'b010);
      chk("stat prio", rd[6:4], 3'd5);
      chk("disarmed", armed, 1'b0);
      srq <= 1'b0;
      repeat (4) @(posedge clk_i);
      wb(4'h4, 1'b1, 32'h4); // poll
      repeat (12) @(posedge clk_i);
      wb(4'hC, 1'b0, 32'h0);
      chk("polled cause", rd, 32'h2);
      chk("cause cleared", cause, 16'h0);
      wb(4'h4, 1'b1, 32'h1); // re-enable, old mask
      repeat (12) @(posedge clk_i);
      wb(4'h8, 1'b0, 32'h0);
      chk("stat reenabled", rd[2:0], 3'b000);
      chk("rearmed", armed, 1'b1);
      wb(4'h0, 1'b0, 32'h0);
      chk("mask kept", rd[15:0], 16'h2);
      @(posedge clk_i);
      cond <= 16'h4;
      @(posedge clk_i);
      cond <= 16'h0;
      repeat (4) @(posedge clk_i);
      chk("cond cause", cause, 16'h4);
      wb(4'h8, 1'b0, 32'h0);
      chk("blocked", rd[2:0], 3'b000);
      wb(4'h0, 1'b1, 32'h0000AA06, 4'h1); // low lane only
      wb(4'h0, 1'b0, 32'h0);
      chk("mask low lane", rd[15:0], 16'h0006);
      wb(4'h4, 1'b1, 32'h1);
      repeat (12) @(posedge clk_i);
      wb(4'h8, 1'b0, 32'h0);
      chk("cond logged", rd[2:0], 3'b010);
      results();
   end
endmodule
